// ==== design/remote_i2c_target_remap.v ====
// address substitution for remote i2c targets 1 to 5 behind the serializer
// assumes a byte register port in the register clock domain and alias values from the decoder
//
// Overview of operation
// - five read/write 8-bit registers hold 7-bit physical addresses in bits 7..1
// - registers for targets 1 to 5 sit at consecutive offsets 9h to Dh
// - an address matching target N's alias is replaced by target N's physical address
// - substitution finishes before the transaction goes to the control channel
// - every register clears to zero on reset, reserved bit included
// - matches come from comparing the incoming address with each programmed alias
// - a zero alias disables matching for its target, so nothing is remapped or forwarded to it
//
// register port: a write lands at its strobe edge, read data one edge later
// read data holds until the next read; unmapped offsets read 00h and no hit
// transaction port: o_txn_match is combinational, o_fwd_* follow one edge later
// o_fwd_addr, o_fwd_rw and o_fwd_target keep their last value between matches
// limitation: duplicate aliases resolve to the lowest target index
// the alias values arrive from the decoder outside; this block never stores them
`timescale 1ns/1ps
`include "remote_target_remap_map.vh"
module remote_i2c_target_remap (
    input wire i_clk, // register clock, 40 MHz
    input wire i_rst, // synchronous reset, active high
    input wire [7:0] i_reg_addr, // register offset
    input wire i_reg_wr, // register write strobe
    input wire i_reg_rd, // register read strobe
    input wire [7:0] i_reg_wdata, // register write data
    output reg [7:0] o_reg_rdata, // register read data
    output reg o_reg_hit, // read addressed one of these registers
    input wire [34:0] i_alias_addrs, // aliases for targets 1..5, 7 bits each, target 1 low
    input wire i_txn_valid, // incoming transaction address is valid
    input wire [6:0] i_txn_addr, // 7-bit address from the local master
    input wire i_txn_rw, // read/write bit of the transaction
    output reg o_fwd_valid, // remapped transaction ready for the control channel
    output reg [6:0] o_fwd_addr, // physical address sent to the serializer
    output reg o_fwd_rw, // read/write bit forwarded unchanged
    output reg [2:0] o_fwd_target, // index 1..5 of the matched target
    output wire o_txn_match // combinational: current address hits a remote target
);
    wire [39:0] regs_flat;
    reg [4:0] wr_sel;
    reg [4:0] match_vec;
    reg [2:0] match_idx;
    reg [6:0] match_phys;
    reg [7:0] rd_mux;

    // stored physical addresses, bits 7..1 of each register
    wire [6:0] target_phys_addr_1;
    wire [6:0] target_phys_addr_2;
    wire [6:0] target_phys_addr_3;
    wire [6:0] target_phys_addr_4;
    wire [6:0] target_phys_addr_5;

    // per-target aliases from the decoder
    wire [6:0] target_alias_addr_1;
    wire [6:0] target_alias_addr_2;
    wire [6:0] target_alias_addr_3;
    wire [6:0] target_alias_addr_4;
    wire [6:0] target_alias_addr_5;

    // index of the register at an offset, 0 when outside 9h..Dh
    function [2:0] target_index;
        input [7:0] ofs;
        reg [7:0] diff;
        begin
            diff = ofs - `RTR_OFS_TARGET_1 + 8'h01;
            if (ofs >= `RTR_OFS_TARGET_1 && ofs <= `RTR_OFS_TARGET_5) begin
                target_index = diff[2:0];
            end else begin
                target_index = 3'd0;
            end
        end
    endfunction

    // one alias compare; a zero alias never matches, so an unused slot stays silent
    function alias_hit;
        input [6:0] alias_val;
        input [6:0] addr;
        begin
            alias_hit = (alias_val != `RTR_ALIAS_OFF) && (alias_val == addr);
        end
    endfunction

    // address field of each register; bit 0 is dropped so the reserved bit cannot leak
    assign target_phys_addr_1 = regs_flat[`RTR_FIELD_ADDR_LO +: 7];
    assign target_phys_addr_2 = regs_flat[8 + `RTR_FIELD_ADDR_LO +: 7];
    assign target_phys_addr_3 = regs_flat[16 + `RTR_FIELD_ADDR_LO +: 7];
    assign target_phys_addr_4 = regs_flat[24 + `RTR_FIELD_ADDR_LO +: 7];
    assign target_phys_addr_5 = regs_flat[32 + `RTR_FIELD_ADDR_LO +: 7];

    // alias slices, target 1 in the low bits
    assign target_alias_addr_1 = i_alias_addrs[6:0];
    assign target_alias_addr_2 = i_alias_addrs[13:7];
    assign target_alias_addr_3 = i_alias_addrs[20:14];
    assign target_alias_addr_4 = i_alias_addrs[27:21];
    assign target_alias_addr_5 = i_alias_addrs[34:28];

    // write decode per target; unmapped offsets strobe nothing
    always @* begin
        wr_sel = 5'h00;
        if (i_reg_wr) begin
            case (target_index(i_reg_addr))
                3'd1: wr_sel = 5'h01;
                3'd2: wr_sel = 5'h02;
                3'd3: wr_sel = 5'h04;
                3'd4: wr_sel = 5'h08;
                3'd5: wr_sel = 5'h10;
                default: wr_sel = 5'h00;
            endcase
        end
    end

    // target 1 register, lowest offset
    target_addr_reg u_target_addr_reg_1 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr_en(wr_sel[0]),
        .i_wr_data(i_reg_wdata),
        .o_value(regs_flat[7:0])
    );

    // target 2 register
    target_addr_reg u_target_addr_reg_2 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr_en(wr_sel[1]),
        .i_wr_data(i_reg_wdata),
        .o_value(regs_flat[15:8])
    );

    // target 3 register
    target_addr_reg u_target_addr_reg_3 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr_en(wr_sel[2]),
        .i_wr_data(i_reg_wdata),
        .o_value(regs_flat[23:16])
    );

    // target 4 register
    target_addr_reg u_target_addr_reg_4 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr_en(wr_sel[3]),
        .i_wr_data(i_reg_wdata),
        .o_value(regs_flat[31:24])
    );

    // target 5 register, highest offset
    target_addr_reg u_target_addr_reg_5 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr_en(wr_sel[4]),
        .i_wr_data(i_reg_wdata),
        .o_value(regs_flat[39:32])
    );

    // alias compare, one hit bit per target
    always @* begin
        match_vec[0] = alias_hit(target_alias_addr_1, i_txn_addr);
        match_vec[1] = alias_hit(target_alias_addr_2, i_txn_addr);
        match_vec[2] = alias_hit(target_alias_addr_3, i_txn_addr);
        match_vec[3] = alias_hit(target_alias_addr_4, i_txn_addr);
        match_vec[4] = alias_hit(target_alias_addr_5, i_txn_addr);
    end

    // lowest index wins if software programs duplicate aliases
    always @* begin
        if (match_vec[0]) begin
            match_idx = 3'd1;
            match_phys = target_phys_addr_1;
        end else if (match_vec[1]) begin
            match_idx = 3'd2;
            match_phys = target_phys_addr_2;
        end else if (match_vec[2]) begin
            match_idx = 3'd3;
            match_phys = target_phys_addr_3;
        end else if (match_vec[3]) begin
            match_idx = 3'd4;
            match_phys = target_phys_addr_4;
        end else if (match_vec[4]) begin
            match_idx = 3'd5;
            match_phys = target_phys_addr_5;
        end else begin
            match_idx = 3'd0;
            match_phys = 7'h00;
        end
    end

    assign o_txn_match = i_txn_valid && (match_vec != 5'h00);

    // forward stage: address already substituted when valid rises
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_fwd_valid <= 1'b0;
            o_fwd_addr <= 7'h00;
            o_fwd_rw <= 1'b0;
            o_fwd_target <= 3'd0;
        end else begin
            o_fwd_valid <= o_txn_match;
            if (o_txn_match) begin
                o_fwd_addr <= match_phys;
                o_fwd_rw <= i_txn_rw;
                o_fwd_target <= match_idx;
            end
        end
    end

    // read mux; zero outside the mapped window so stale bytes never show
    always @* begin
        case (target_index(i_reg_addr))
            3'd1: rd_mux = regs_flat[7:0];
            3'd2: rd_mux = regs_flat[15:8];
            3'd3: rd_mux = regs_flat[23:16];
            3'd4: rd_mux = regs_flat[31:24];
            3'd5: rd_mux = regs_flat[39:32];
            default: rd_mux = 8'h00;
        endcase
    end

    // registered read port, one cycle after the strobe; data holds between reads
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata <= `RTR_RESET_VALUE;
            o_reg_hit <= 1'b0;
        end else if (i_reg_rd) begin
            o_reg_hit <= target_index(i_reg_addr) != 3'd0;
            o_reg_rdata <= rd_mux;
        end else begin
            o_reg_hit <= 1'b0;
        end
    end
endmodule // remote_i2c_target_remap

// ==== design/remote_target_remap_map.vh ====
// register offsets, field positions and reset values for the remote target remap block
// assumes an 8-bit register port with byte-wide offsets
`ifndef REMOTE_TARGET_REMAP_MAP_VH
`define REMOTE_TARGET_REMAP_MAP_VH
`define RTR_ADDR_W 8
`define RTR_OFS_TARGET_1 8'h09
`define RTR_OFS_TARGET_2 8'h0A
`define RTR_OFS_TARGET_3 8'h0B
`define RTR_OFS_TARGET_4 8'h0C
`define RTR_OFS_TARGET_5 8'h0D
`define RTR_NUM_TARGETS 5
`define RTR_FIELD_ADDR_HI 7
`define RTR_FIELD_ADDR_LO 1
`define RTR_FIELD_RSVD 0
`define RTR_RESET_VALUE 8'h00
`define RTR_ALIAS_OFF 7'h00
`endif

// ==== design/target_addr_reg.v ====
// one remote target address register: 7-bit physical address plus reserved bit
// assumes the parent decodes the register offset into i_wr_en
`timescale 1ns/1ps
`include "remote_target_remap_map.vh"
module target_addr_reg (
    input wire i_clk, // register clock
    input wire i_rst, // synchronous reset, active high
    input wire i_wr_en, // write strobe for this register
    input wire [7:0] i_wr_data, // write data
    output wire [7:0] o_value // stored byte
);
    reg [7:0] value_q;
    // whole byte stored, reserved bit included so it reads back as written
    always @(posedge i_clk) begin
        if (i_rst) begin
            value_q <= `RTR_RESET_VALUE;
        end else if (i_wr_en) begin
            value_q <= i_wr_data;
        end
    end
    assign o_value = value_q;
endmodule // target_addr_reg

// ==== verif/rtr_properties.sv ====
// port checker for the remote target remap block
// assumes a bind onto the top module, one clock domain
`timescale 1ns/1ps
module rtr_properties(input wire i_clk, i_rst, i_reg_wr, i_reg_rd, i_txn_valid, i_txn_rw,
    o_reg_hit, o_fwd_valid, o_fwd_rw, o_txn_match, input wire [7:0] i_reg_addr, i_reg_wdata,
    o_reg_rdata, input wire [34:0] i_alias_addrs, input wire [6:0] i_txn_addr, o_fwd_addr,
    input wire [2:0] o_fwd_target);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // mapped window, unmapped reads must not flag a hit
    wire mapped = i_reg_addr >= 8'h09 && i_reg_addr <= 8'h0D;
    sequence s_hit1;
        i_txn_valid && i_alias_addrs[6:0] != 7'h00 && i_txn_addr == i_alias_addrs[6:0];
    endsequence
    sequence s_wr_rd;
        i_reg_wr && i_reg_addr == 8'h09 ##1 !i_reg_wr
            ##1 i_reg_rd && !i_reg_wr && i_reg_addr == 8'h09;
    endsequence
    a_match_alias: assert property (s_hit1 |-> o_txn_match) else $error("hit missed");
    a_first_target: assert property (s_hit1 |=> o_fwd_target == 3'h1) else $error("bad index");
    a_alias_off: assert property (i_alias_addrs == 35'h0 |-> !o_txn_match) else $error("zero hit");
    a_fwd_after: assert property (o_txn_match |=> o_fwd_valid) else $error("no forward");
    a_no_fwd: assert property (!o_txn_match |=> !o_fwd_valid) else $error("stray forward");
    a_rw_copy: assert property (o_txn_match |=> o_fwd_rw == $past(i_txn_rw)) else $error("rw lost");
    a_read_hit: assert property (i_reg_rd |=> o_reg_hit == $past(mapped)) else $error("bad hit");
    a_write_back: assert property (s_wr_rd |=> o_reg_rdata == $past(i_reg_wdata, 3))
        else $error("bad readback");
endmodule // rtr_properties
bind remote_i2c_target_remap rtr_properties u_rtr_properties(.*);

// ==== verif/rtr_serializer_model.sv ====
// far-end sink: counts remapped transactions reaching the channel
// assumes forwards arrive as one-cycle valid pulses
`timescale 1ns/1ps
module rtr_serializer_model(input wire i_clk, input wire i_valid, output int o_count);
    initial o_count = 0;
    // every pulse is one transaction, already remapped
    always @(posedge i_clk) begin
        if (i_valid) o_count <= o_count + 1;
    end
endmodule // rtr_serializer_model

// ==== verif/remote_i2c_target_remap_tb.sv ====
// self-checking bench for the remote target remap block
// assumes the serializer model and bound checker are compiled alongside
`timescale 1ns/1ps
module remote_i2c_target_remap_tb;
    reg clk = 0, rst = 1, wr = 0, rd = 0, tv = 0, trw = 0, r;
    reg [7:0] ra = 0, wd = 0;
    reg [6:0] ta = 0;
    reg [34:0] al = 0;
    reg [7:0] mdl [1:5];
    wire [7:0] rdat;
    wire hit, fv, frw, m;
    wire [6:0] fa;
    wire [2:0] ft;
    int cnt, n, fail_count = 0, checked = 0, seed = 32, cyc = 0;
    remote_i2c_target_remap u_remote_i2c_target_remap(.i_clk(clk), .i_rst(rst), .i_reg_addr(ra),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_hit(hit),
        .i_alias_addrs(al), .i_txn_valid(tv), .i_txn_addr(ta), .i_txn_rw(trw), .o_fwd_valid(fv),
        .o_fwd_addr(fa), .o_fwd_rw(frw), .o_fwd_target(ft), .o_txn_match(m));
    rtr_serializer_model u_rtr_serializer_model(.i_clk(clk), .i_valid(fv), .o_count(cnt));
    initial forever #12.5 clk = ~clk;
    // hang guard, the run needs about 65 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin fail_count++; wrap_up; end
    end
    task chk(input logic [31:0] s, e);
        checked++;
        if (s !== e) begin fail_count++; $display("unexpected %0t seen %0h exp %0h", $time, s, e); end
    endtask
    task wrr(input [7:0] a, d);
        @(posedge clk) begin ra <= a; wd <= d; wr <= 1; end
        @(posedge clk) wr <= 0;
    endtask
    task rdc(input [7:0] a, e, input h);
        @(posedge clk) begin ra <= a; rd <= 1; end
        @(posedge clk) rd <= 0;
        #1 chk(rdat, e);
        chk(hit, h);
    endtask
    // expected forward from the model: bit 0 never leaves the register
    task tx(input [6:0] a, input ev, input [2:0] k);
        r = $random(seed);
        @(posedge clk) begin ta <= a; trw <= r; tv <= 1; end
        #1 chk(m, ev);
        @(posedge clk) tv <= 0;
        #1 chk(fv, ev);
        if (ev) begin chk(fa, mdl[k][7:1]); chk(ft, k); chk(frw, r); end
    endtask
    task wrap_up;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        for (n = 8; n < 15; n++) rdc(n, 0, n > 8 && n < 14);
        tx(7'h00, 0, 0);
        wrr(8'h0E, 8'hFF);
        // both values of the reserved bit are stored across the five registers
        for (n = 5; n > 0; n--) begin
            mdl[n] = $random(seed);
            mdl[n][0] = n[0];
            wrr(8 + n, mdl[n]);
        end
        for (n = 9; n < 15; n++) rdc(n, n < 14 ? mdl[n - 8] : 0, n < 14);
        @(posedge clk) al <= {7'h15, 7'h14, 7'h13, 7'h12, 7'h11};
        for (n = 1; n < 6; n++) tx(7'h10 + n, 1, n);
        tx(7'h16, 0, 0);
        @(posedge clk) al[20:14] <= 7'h00;
        tx(7'h13, 0, 0);
        tx(7'h00, 0, 0);
        chk(cnt, 5);
        wrap_up;
    end
endmodule // remote_i2c_target_remap_tb
